/* File: inc/tcal_pkg.sv */
// Purpose: Shared constants for the tag configuration area and lock logic
// Assumes: One 50 MHz clock; pages are 4 bytes, byte 0 in bits 7:0
// Notes: Processor register indices form a small local register port
package tcal_pkg;
   // Memory geometry
   localparam int PAGE_W = 7;
   localparam int PAGE_COUNT = 80;
   localparam int NV_PAGE_COUNT = 64;
   localparam int WORD_W = 32;
   localparam logic [6:0] PAGE_SERIAL_A = 7'h00;
   localparam logic [6:0] PAGE_SERIAL_B = 7'h01;
   localparam logic [6:0] PAGE_LOCK = 7'h02;
   localparam logic [6:0] PAGE_CAP = 7'h03;
   localparam logic [6:0] PAGE_USER_FIRST = 7'h04;
   localparam logic [6:0] PAGE_LOCKABLE_LAST = 7'h0f;
   localparam logic [6:0] PAGE_END = 7'h50;

   // Check byte seed
   localparam logic [7:0] CASCADE_TAG = 8'h88;
   // Arbitrary content of the internal reserved byte
   localparam logic [7:0] INTERNAL_BYTE = 8'h00;

   // Reset values
   localparam logic [7:0] LOCK_RESET = 8'h00;
   localparam logic [7:0] CAP0_RESET = 8'he1;
   localparam logic [7:0] CAP1_RESET = 8'h10;
   localparam logic [7:0] CAP2_RESET = 8'h26;
   localparam logic [7:0] CAP3_RESET = 8'h00;

   // Field positions in static_lock_low
   localparam int LK_CAP_BLOCK = 0;
   localparam int LK_LOWER_BLOCK = 1;
   localparam int LK_UPPER_BLOCK = 2;
   localparam int LK_CAP_PAGE = 3;

   // Processor register indices
   localparam int SFR_AW = 4;
   localparam logic [3:0] REG_PAGE_ADDR = 4'h0;
   localparam logic [3:0] REG_DATA0 = 4'h1;
   localparam logic [3:0] REG_DATA3 = 4'h4;
   localparam logic [3:0] REG_ACCESS = 4'h5;
   localparam logic [3:0] REG_CTRL = 4'h6;
   localparam logic [3:0] REG_LAST_WR = 4'h7;
   localparam logic [3:0] REG_STATE = 4'h8;

   // mcu_access_control fields
   localparam int ACC_RD_GO = 0;
   localparam int ACC_RD_EN = 1;
   localparam int ACC_WR_GO = 2;
   localparam int ACC_WR_EN = 3;

   // tag_module_control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_FCOND_LO = 1;
   localparam int CTRL_MOD_MODE = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
endpackage : tcal_pkg

/* File: logic/tcal_page_mem.sv */
// Purpose: User page storage, one write port and two registered read ports
// Assumes: Write and read addresses are already range checked
// Notes: Read of a page written in the same cycle returns the old word
module tcal_page_mem #(
   parameter int DEPTH = 80,
   parameter int AW = 7,
   parameter int DW = 32
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Write port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // Read ports
   input wire logic [AW-1:0] ra_addr_i,
   output logic [DW-1:0] ra_data_o,
   input wire logic [AW-1:0] rb_addr_i,
   output logic [DW-1:0] rb_data_o
);
   logic [DW-1:0] mem_reg [DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ra_data_o <= '0;
         rb_data_o <= '0;
      end else begin
         ra_data_o <= mem_reg[ra_addr_i];
         rb_data_o <= mem_reg[rb_addr_i];
      end
   end
endmodule : tcal_page_mem

/* File: logic/tcal_config_lock.sv */
// Purpose: Tag configuration pages, lock bits and processor page access
// Assumes: Fuse serial bytes are static; RF strobes are on core_clk_i
// Notes: RF write has priority; a processor write waits out each taken RF write slot
module tcal_config_lock #(
   parameter int PAGES = tcal_pkg::PAGE_COUNT
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Fuse serial number, byte n in bits 8n+7:8n
   input wire logic [55:0] fuse_sn_i,
   // Processor register port
   input wire logic [tcal_pkg::SFR_AW-1:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // RF command side
   input wire logic rf_wr_i,
   input wire logic rf_rd_i,
   input wire logic [tcal_pkg::PAGE_W-1:0] rf_page_i,
   input wire logic [31:0] rf_wdata_i,
   output logic [31:0] rf_rdata_o,
   output logic rf_rvalid_o,
   // Module control and visible configuration
   output logic tag_enable_o,
   output logic [1:0] field_cond_select_o,
   output logic mod_mode_o,
   output logic [7:0] static_lock_low_o,
   output logic [7:0] static_lock_high_o,
   output logic [31:0] cap_container_o
);
   logic boot_done_reg;
   logic [55:0] serial_reg;
   logic [7:0] static_lock_low_reg;
   logic [7:0] static_lock_high_reg;
   logic [7:0] cap_reg [4];
   logic [6:0] mcu_page_addr_reg;
   logic [7:0] mcu_data_reg [4];
   logic [3:0] mcu_access_reg;
   logic [3:0] ctrl_reg;
   logic [6:0] rf_last_write_page_reg;
   logic [7:0] block_check0;
   logic [7:0] block_check1;
   logic [31:0] cfg_word [4];
   logic rf_wr_take;
   logic rf_rd_take;
   logic mcu_wr_take;
   logic mcu_rd_take;
   logic wr_fire;
   logic [6:0] wr_page;
   logic [31:0] wr_data;
   logic mem_we;
   logic [7:0] lock_low_next;
   logic [7:0] lock_high_next;
   logic [31:0] rf_mem_q;
   logic [31:0] mcu_mem_q;
   logic rf_rd_q;
   logic rf_cfg_q;
   logic [31:0] rf_cfg_word_q;
   logic mcu_rd_q;
   logic mcu_cfg_q;
   logic [31:0] mcu_cfg_word_q;
   logic [7:0] sfr_read_val;

   // Locked state of one page from the two lock bytes
   function automatic logic page_is_locked(input logic [6:0] page, input logic [7:0] lo,
                                          input logic [7:0] hi);
      logic res;
      res = 1'b0;
      if (page == tcal_pkg::PAGE_CAP) begin
         res = lo[tcal_pkg::LK_CAP_PAGE];
      end else if (page >= tcal_pkg::PAGE_USER_FIRST && page < 7'h08) begin
         res = lo[{1'b1, page[1:0]}];
      end else if (page >= 7'h08 && page <= tcal_pkg::PAGE_LOCKABLE_LAST) begin
         res = hi[page[2:0]];
      end
      return res;
   endfunction : page_is_locked

   // Check bytes follow the serial bytes
   assign block_check0 = tcal_pkg::CASCADE_TAG ^ serial_reg[7:0] ^ serial_reg[15:8]
                         ^ serial_reg[23:16];
   assign block_check1 = serial_reg[31:24] ^ serial_reg[39:32] ^ serial_reg[47:40]
                         ^ serial_reg[55:48];
   assign cfg_word[0] = {block_check0, serial_reg[23:0]};
   assign cfg_word[1] = serial_reg[55:24];
   assign cfg_word[2] = {static_lock_high_reg, static_lock_low_reg, tcal_pkg::INTERNAL_BYTE,
                         block_check1};
   // Capability bytes are stored and reported only; nothing gates access on them
   assign cfg_word[3] = {cap_reg[3], cap_reg[2], cap_reg[1], cap_reg[0]};

   // Serial bytes latched once after reset release
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         boot_done_reg <= 1'b0;
         serial_reg <= '0;
      end else if (!boot_done_reg) begin
         boot_done_reg <= 1'b1;
         serial_reg <= fuse_sn_i;
      end
   end

   // Request selection: RF first, processor write waits
   assign rf_wr_take = rf_wr_i && tag_enable_o && boot_done_reg;
   assign rf_rd_take = rf_rd_i && tag_enable_o && boot_done_reg;
   assign mcu_wr_take = mcu_access_reg[tcal_pkg::ACC_WR_GO] && mcu_access_reg[tcal_pkg::ACC_WR_EN]
                        && boot_done_reg && !rf_wr_take;
   assign mcu_rd_take = mcu_access_reg[tcal_pkg::ACC_RD_GO] && mcu_access_reg[tcal_pkg::ACC_RD_EN]
                        && boot_done_reg;
   assign wr_fire = rf_wr_take || mcu_wr_take;
   assign wr_page = rf_wr_take ? rf_page_i : mcu_page_addr_reg;
   assign wr_data = rf_wr_take ? rf_wdata_i : {mcu_data_reg[3], mcu_data_reg[2], mcu_data_reg[1],
                                               mcu_data_reg[0]};
   // Pages 0 and 1 and anything past the end never take a write
   assign mem_we = wr_fire && wr_page >= tcal_pkg::PAGE_USER_FIRST
                   && wr_page < tcal_pkg::PAGE_END
                   && !page_is_locked(wr_page, static_lock_low_reg, static_lock_high_reg);

   // OR merge with block lock masking
   always_comb begin
      lock_low_next = static_lock_low_reg;
      lock_high_next = static_lock_high_reg;
      lock_low_next[2:0] = static_lock_low_reg[2:0] | wr_data[18:16];
      if (!static_lock_low_reg[tcal_pkg::LK_LOWER_BLOCK]) begin
         lock_low_next[7:4] = static_lock_low_reg[7:4] | wr_data[23:20];
         lock_high_next[1:0] = static_lock_high_reg[1:0] | wr_data[25:24];
      end
      if (!static_lock_low_reg[tcal_pkg::LK_CAP_BLOCK]) begin
         lock_low_next[3] = static_lock_low_reg[3] | wr_data[19];
      end
      if (!static_lock_low_reg[tcal_pkg::LK_UPPER_BLOCK]) begin
         lock_high_next[7:2] = static_lock_high_reg[7:2] | wr_data[31:26];
      end
   end

   // Lock bytes; bytes 0 and 1 of the page 2 word are dropped
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         static_lock_low_reg <= tcal_pkg::LOCK_RESET;
         static_lock_high_reg <= tcal_pkg::LOCK_RESET;
      end else if (wr_fire && wr_page == tcal_pkg::PAGE_LOCK) begin
         static_lock_low_reg <= lock_low_next;
         static_lock_high_reg <= lock_high_next;
      end
   end

   // Capability bytes
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cap_reg[0] <= tcal_pkg::CAP0_RESET;
         cap_reg[1] <= tcal_pkg::CAP1_RESET;
         cap_reg[2] <= tcal_pkg::CAP2_RESET;
         cap_reg[3] <= tcal_pkg::CAP3_RESET;
      end else if (wr_fire && wr_page == tcal_pkg::PAGE_CAP
                   && !static_lock_low_reg[tcal_pkg::LK_CAP_PAGE]) begin
         for (int i = 0; i < 4; i++) begin
            cap_reg[i] <= cap_reg[i] | wr_data[8*i +: 8];
         end
      end
   end

   tcal_page_mem #(
      .DEPTH(PAGES),
      .AW(tcal_pkg::PAGE_W),
      .DW(tcal_pkg::WORD_W)
   ) u_mem (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .we_i(mem_we),
      .waddr_i(wr_page),
      .wdata_i(wr_data),
      .ra_addr_i(rf_page_i < tcal_pkg::PAGE_END ? rf_page_i : '0),
      .ra_data_o(rf_mem_q),
      .rb_addr_i(mcu_page_addr_reg < tcal_pkg::PAGE_END ? mcu_page_addr_reg : '0),
      .rb_data_o(mcu_mem_q)
   );

   // RF read pipeline, answer two edges after the request
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rf_rd_q <= 1'b0;
         rf_cfg_q <= 1'b0;
         rf_cfg_word_q <= '0;
         rf_rdata_o <= '0;
         rf_rvalid_o <= 1'b0;
      end else begin
         rf_rd_q <= rf_rd_take;
         // Pages past the end take the zero word of the config path
         rf_cfg_q <= (rf_page_i < tcal_pkg::PAGE_USER_FIRST)
                     || (rf_page_i >= tcal_pkg::PAGE_END);
         rf_cfg_word_q <= rf_page_i >= tcal_pkg::PAGE_END ? '0 : cfg_word[rf_page_i[1:0]];
         rf_rvalid_o <= rf_rd_q;
         if (rf_rd_q) begin
            rf_rdata_o <= rf_cfg_q ? rf_cfg_word_q : rf_mem_q;
         end
      end
   end

   // Last RF written page
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rf_last_write_page_reg <= '0;
      end else if (rf_wr_take) begin
         rf_last_write_page_reg <= rf_page_i;
      end
   end

   // Processor read capture
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mcu_rd_q <= 1'b0;
         mcu_cfg_q <= 1'b0;
         mcu_cfg_word_q <= '0;
      end else begin
         mcu_rd_q <= mcu_rd_take;
         mcu_cfg_q <= (mcu_page_addr_reg < tcal_pkg::PAGE_USER_FIRST)
                      || (mcu_page_addr_reg >= tcal_pkg::PAGE_END);
         mcu_cfg_word_q <= mcu_page_addr_reg >= tcal_pkg::PAGE_END ? '0
                           : cfg_word[mcu_page_addr_reg[1:0]];
      end
   end

   // Processor registers; hardware loads win over data writes, an access write wins over go clears
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mcu_page_addr_reg <= '0;
         mcu_access_reg <= '0;
         ctrl_reg <= tcal_pkg::CTRL_RESET;
         for (int i = 0; i < 4; i++) begin
            mcu_data_reg[i] <= '0;
         end
      end else begin
         if (sfr_wr_i && sfr_addr_i == tcal_pkg::REG_PAGE_ADDR) begin
            mcu_page_addr_reg <= sfr_wdata_i[6:0];
         end
         if (sfr_wr_i && sfr_addr_i == tcal_pkg::REG_CTRL) begin
            ctrl_reg <= sfr_wdata_i[3:0];
         end
         for (int i = 0; i < 4; i++) begin
            if (mcu_rd_q) begin
               mcu_data_reg[i] <= mcu_cfg_q ? mcu_cfg_word_q[8*i +: 8]
                                            : mcu_mem_q[8*i +: 8];
            end else if (sfr_wr_i && sfr_addr_i == tcal_pkg::REG_DATA0 + 4'(i)) begin
               mcu_data_reg[i] <= sfr_wdata_i;
            end
         end
         if (sfr_wr_i && sfr_addr_i == tcal_pkg::REG_ACCESS) begin
            mcu_access_reg <= sfr_wdata_i[3:0];
         end else begin
            if (mcu_wr_take) begin
               mcu_access_reg[tcal_pkg::ACC_WR_GO] <= 1'b0;
            end
            if (mcu_rd_take) begin
               mcu_access_reg[tcal_pkg::ACC_RD_GO] <= 1'b0;
            end
         end
      end
   end

   assign tag_enable_o = ctrl_reg[tcal_pkg::CTRL_ENABLE];
   assign field_cond_select_o = ctrl_reg[tcal_pkg::CTRL_FCOND_LO +: 2];
   assign mod_mode_o = ctrl_reg[tcal_pkg::CTRL_MOD_MODE];
   assign static_lock_low_o = static_lock_low_reg;
   assign static_lock_high_o = static_lock_high_reg;
   assign cap_container_o = cfg_word[3];

   // Register read decode
   always_comb begin
      sfr_read_val = '0;
      case (sfr_addr_i)
         tcal_pkg::REG_PAGE_ADDR: sfr_read_val = {1'b0, mcu_page_addr_reg};
         tcal_pkg::REG_ACCESS: sfr_read_val = {4'h0, mcu_access_reg};
         tcal_pkg::REG_CTRL: sfr_read_val = {4'h0, ctrl_reg};
         tcal_pkg::REG_LAST_WR: sfr_read_val = {1'b0, rf_last_write_page_reg};
         tcal_pkg::REG_STATE: sfr_read_val = {4'h0, !boot_done_reg, mcu_rd_q,
                                              mcu_access_reg[tcal_pkg::ACC_WR_GO], tag_enable_o};
         default: begin
            if (sfr_addr_i >= tcal_pkg::REG_DATA0 && sfr_addr_i <= tcal_pkg::REG_DATA3) begin
               sfr_read_val = mcu_data_reg[2'(sfr_addr_i - tcal_pkg::REG_DATA0)];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= '0;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= sfr_read_val;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   serial_stable_a: assert property (boot_done_reg |=> $stable(serial_reg))
      else $error("serial bytes changed after load");
   check_zero_a: assert property (rf_rvalid_o && $past(rf_page_i, 2) == 7'h00
         |-> rf_rdata_o[31:24] == (8'h88 ^ rf_rdata_o[7:0] ^ rf_rdata_o[15:8]
                                   ^ rf_rdata_o[23:16]))
      else $error("first check byte wrong");
   cap_lock_a: assert property (wr_fire && wr_page == 7'h03 && static_lock_low_reg[3]
         |=> $stable(cap_container_o))
      else $error("locked capability page changed");
   upper_block_a: assert property (static_lock_low_reg[2] |=> $stable(static_lock_high_reg[7:2]))
      else $error("upper lock bits changed under block lock");
   lower_block_a: assert property (static_lock_low_reg[1]
         |=> $stable(static_lock_low_reg[7:4]) && $stable(static_lock_high_reg[1:0]))
      else $error("lower lock bits changed under block lock");
   cap_block_a: assert property (static_lock_low_reg[0] |=> $stable(static_lock_low_reg[3]))
      else $error("capability lock bit changed under block lock");
   locked_write_a: assert property (mem_we && wr_page >= 7'h04 && wr_page <= 7'h0f
         |-> !(wr_page < 7'h08 ? static_lock_low_reg[wr_page[2:0]]
                               : static_lock_high_reg[wr_page[2:0]]))
      else $error("write reached a locked page");
   lock_sticky_a: assert property (##1 ((static_lock_low_reg & $past(static_lock_low_reg))
         == $past(static_lock_low_reg)))
      else $error("lock bit cleared");
   last_page_a: assert property (rf_wr_take |=> rf_last_write_page_reg == $past(rf_page_i))
      else $error("last RF page not recorded");
   rf_read_a: assert property (rf_rd_take |-> ##2 rf_rvalid_o)
      else $error("RF read answer missing");

   lock_write_c: cover property (wr_fire && wr_page == tcal_pkg::PAGE_LOCK);
   cap_write_c: cover property (wr_fire && wr_page == tcal_pkg::PAGE_CAP);
   mcu_read_c: cover property (mcu_rd_q);
   blocked_c: cover property (wr_fire && !mem_we && wr_page >= tcal_pkg::PAGE_USER_FIRST);
endmodule : tcal_config_lock

/* File: testbench/tcal_rf_reader.sv */
// Purpose: Behavioural contactless reader driving page reads and writes
// Assumes: Requests change just after a falling edge, taken on the next rise
// Notes: Released address and data lines show the inverse of the last value
module tcal_rf_reader (
   // Clock
   input wire logic core_clk_i,
   // Requests toward the tag
   output logic rf_wr_o,
   output logic rf_rd_o,
   output logic [6:0] rf_page_o,
   output logic [31:0] rf_wdata_o,
   // Answers from the tag
   input wire logic [31:0] rf_rdata_i,
   input wire logic rf_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rf_wr_o = 1'b0;
      rf_rd_o = 1'b0;
      rf_page_o = 7'h7f;
      rf_wdata_o = 32'h0000_0000;
   end

   task automatic write_page(input logic [6:0] page, input logic [31:0] data);
      @(negedge core_clk_i);
      rf_page_o = page;
      rf_wdata_o = data;
      rf_wr_o = 1'b1;
      @(negedge core_clk_i);
      rf_wr_o = 1'b0;
      rf_page_o = ~page;
      rf_wdata_o = ~data;
      repeat (2) @(negedge core_clk_i);
   endtask : write_page

   // Seen only if the answer shows after the edge that follows the taking edge, not before
   task automatic read_page(input logic [6:0] page, output logic [31:0] data,
                            output logic seen);
      logic early;
      @(negedge core_clk_i);
      rf_page_o = page;
      rf_rd_o = 1'b1;
      @(posedge core_clk_i);
      #1 early = rf_rvalid_i;
      @(negedge core_clk_i);
      rf_rd_o = 1'b0;
      rf_page_o = ~page;
      @(posedge core_clk_i);
      #1 seen = (rf_rvalid_i === 1'b1) && (early === 1'b0);
      data = rf_rdata_i;
      @(negedge core_clk_i);
   endtask : read_page
endmodule : tcal_rf_reader

/* File: testbench/tag_config_area_lock_logic_tb_top.sv */
// Purpose: Self-checking bench for the tag configuration and lock logic
// Assumes: Inputs change on the falling edge; fuse value held static
// Notes: A mid-run reset restores factory lock and capability values
module tag_config_area_lock_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [55:0] SN = 56'h7d_6c5b_4a39_2817;
   localparam logic [7:0] BCC0 = 8'h88 ^ SN[7:0] ^ SN[15:8] ^ SN[23:16];
   localparam logic [7:0] BCC1 = SN[31:24] ^ SN[39:32] ^ SN[47:40] ^ SN[55:48];

   logic core_clk_i, sys_rst_i, sfr_wr_i, sfr_rd_i, rf_wr, rf_rd, rf_rvalid;
   logic tag_en, mod_mode;
   logic [1:0] fcond;
   logic [3:0] sfr_addr_i;
   logic [7:0] sfr_wdata_i, sfr_rdata_o, lock_lo, lock_hi;
   logic [6:0] rf_page;
   logic [31:0] rf_wdata, rf_rdata, cap;
   int n_errors, compares;

   tcal_config_lock dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .fuse_sn_i(SN), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .rf_wr_i(rf_wr),
      .rf_rd_i(rf_rd), .rf_page_i(rf_page), .rf_wdata_i(rf_wdata), .rf_rdata_o(rf_rdata),
      .rf_rvalid_o(rf_rvalid), .tag_enable_o(tag_en), .field_cond_select_o(fcond),
      .mod_mode_o(mod_mode), .static_lock_low_o(lock_lo), .static_lock_high_o(lock_hi),
      .cap_container_o(cap));

   tcal_rf_reader rf_u (.core_clk_i(core_clk_i), .rf_wr_o(rf_wr), .rf_rd_o(rf_rd),
      .rf_page_o(rf_page), .rf_wdata_o(rf_wdata), .rf_rdata_i(rf_rdata),
      .rf_rvalid_i(rf_rvalid));

   always #10 core_clk_i = ~core_clk_i;

   task automatic final_report();
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic sfr_write(input logic [3:0] idx, input logic [7:0] val);
      @(negedge core_clk_i);
      sfr_addr_i = idx;
      sfr_wdata_i = val;
      sfr_wr_i = 1'b1;
      @(negedge core_clk_i);
      sfr_wr_i = 1'b0;
   endtask : sfr_write

   task automatic sfr_read(input logic [3:0] idx, output logic [7:0] val);
      @(negedge core_clk_i);
      sfr_addr_i = idx;
      sfr_rd_i = 1'b1;
      @(negedge core_clk_i);
      sfr_rd_i = 1'b0;
      val = sfr_rdata_o;
   endtask : sfr_read

   task automatic rd_chk(input logic [6:0] p, input logic [31:0] exp);
      logic [31:0] d;
      logic ok;
      rf_u.read_page(p, d, ok);
      cmp_byte({7'h00, ok}, 8'h01);
      cmp_word(d, exp);
   endtask : rd_chk

   task automatic lk_chk(input logic [7:0] lo, input logic [7:0] hi);
      cmp_byte(lock_lo, lo);
      cmp_byte(lock_hi, hi);
   endtask : lk_chk

   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (12) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      sfr_write(tcal_pkg::REG_CTRL, 8'h01);
   endtask : do_reset

   task automatic t_reset_values();
      cmp_word(cap, 32'h0026_10e1);
      cmp_word(32'(cap[23:16]) * 32'h0000_0008, 32'h0000_0130);
      cmp_byte({cap[15:12], cap[11:8]}, 8'h10);
      lk_chk(8'h00, 8'h00);
   endtask : t_reset_values

   task automatic t_module_ctrl();
      logic [31:0] d;
      logic ok;
      sfr_write(tcal_pkg::REG_CTRL, 8'h0e);
      cmp_byte({4'h0, mod_mode, fcond, tag_en}, 8'h0e);
      rf_u.read_page(7'h03, d, ok);
      cmp_byte({7'h00, ok}, 8'h00);
      sfr_write(tcal_pkg::REG_CTRL, 8'h01);
      cmp_byte({4'h0, mod_mode, fcond, tag_en}, 8'h01);
   endtask : t_module_ctrl

   task automatic t_serial();
      for (int k = 0; k < 2; k++) begin
         rd_chk(7'h00, {BCC0, SN[23:0]});
         rd_chk(7'h01, SN[55:24]);
         rd_chk(7'h02, {24'h00_0000, BCC1});
         rf_u.write_page(7'h00, 32'hffff_ffff);
         rf_u.write_page(7'h01, 32'hffff_ffff);
         rf_u.write_page(7'h02, 32'h0000_ffff);
      end
   endtask : t_serial

   task automatic t_cap_merge();
      rf_u.write_page(7'h03, 32'h0f00_0000);
      cmp_word(cap, 32'h0f26_10e1);
      rf_u.write_page(7'h03, 32'hf000_0000);
      rd_chk(7'h03, 32'hff26_10e1);
      rf_u.write_page(7'h03, 32'h0000_0000);
      cmp_word(cap, 32'hff26_10e1);
      rf_u.write_page(7'h04, 32'h5a5a_a5a5);
      rd_chk(7'h04, 32'h5a5a_a5a5);
   endtask : t_cap_merge

   task automatic t_page_locks();
      logic [31:0] w;
      for (int p = 4; p < 16; p++) begin
         rf_u.write_page(7'(p), {4{1'b0, 7'(p)}});
      end
      rf_u.write_page(7'h02, 32'h8190_0000);
      lk_chk(8'h90, 8'h81);
      for (int p = 4; p < 16; p++) begin
         w = {4{1'b0, 7'(p)}};
         rf_u.write_page(7'(p), ~w);
         rd_chk(7'(p), (p inside {4, 7, 8, 15}) ? w : ~w);
      end
   endtask : t_page_locks

   task automatic t_block_locks();
      rf_u.write_page(7'h02, 32'h0004_0000);
      rf_u.write_page(7'h02, 32'h7c20_0000);
      lk_chk(8'hb4, 8'h81);
      rf_u.write_page(7'h02, 32'h0002_0000);
      rf_u.write_page(7'h02, 32'h0240_0000);
      lk_chk(8'hb6, 8'h81);
      rf_u.write_page(7'h02, 32'h0001_0000);
      rf_u.write_page(7'h02, 32'h0008_0000);
      lk_chk(8'hb7, 8'h81);
   endtask : t_block_locks

   task automatic t_cap_lock();
      rf_u.write_page(7'h02, 32'h0008_0000);
      rf_u.write_page(7'h03, 32'h0000_0002);
      rd_chk(7'h03, 32'h0026_10e1);
      rf_u.write_page(7'h02, 32'h0000_0000);
      lk_chk(8'h08, 8'h00);
   endtask : t_cap_lock

   task automatic mcu_write(input logic [6:0] p, input logic [31:0] d);
      sfr_write(tcal_pkg::REG_PAGE_ADDR, {1'b0, p});
      for (int i = 0; i < 4; i++) begin
         sfr_write(4'(i + 1), d[8*i +: 8]);
      end
      sfr_write(tcal_pkg::REG_ACCESS, 8'h0c);
      repeat (3) @(negedge core_clk_i);
   endtask : mcu_write

   task automatic t_mcu_access();
      logic [7:0] b;
      mcu_write(7'h46, 32'hcafe_0b0e);
      rd_chk(7'h46, 32'hcafe_0b0e);
      rf_u.write_page(7'h4f, 32'h1234_5678);
      sfr_read(tcal_pkg::REG_LAST_WR, b);
      cmp_byte(b, 8'h4f);
      sfr_write(tcal_pkg::REG_PAGE_ADDR, 8'h4f);
      sfr_write(tcal_pkg::REG_ACCESS, 8'h03);
      repeat (3) @(negedge core_clk_i);
      for (int i = 0; i < 4; i++) begin
         sfr_read(4'(i + 1), b);
         cmp_byte(b, 8'(32'h1234_5678 >> (8 * i)));
      end
      sfr_read(4'hf, b);
      cmp_byte(b, 8'h00);
      sfr_read(tcal_pkg::REG_STATE, b);
      cmp_byte(b, 8'h01);
      rd_chk(7'h50, 32'h0000_0000);
      mcu_write(7'h01, 32'hffff_ffff);
      rd_chk(7'h01, SN[55:24]);
   endtask : t_mcu_access

   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      $display("mismatch at %0t: run did not finish in time", $time);
      final_report();
   end

   initial begin
      core_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      sfr_addr_i = 4'h0;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      sfr_wdata_i = 8'h00;
      n_errors = 0;
      compares = 0;
      do_reset();
      t_reset_values();
      t_module_ctrl();
      t_serial();
      t_cap_merge();
      t_page_locks();
      t_block_locks();
      do_reset();
      t_reset_values();
      t_cap_lock();
      t_mcu_access();
      final_report();
   end
endmodule : tag_config_area_lock_logic_tb_top
